// File: core/bfci_pkg.sv
package bfci_pkg;

  localparam int          BFCI_ADDR_W        = 19;
  localparam int          BFCI_DATA_W        = 8;
  localparam int          BFCI_SECTOR_COUNT  = 512;
  localparam int          BFCI_SECTOR_BYTES  = 1024;
  localparam int          BFCI_BOOT_SECTORS  = 16;
  localparam logic [18:0] BFCI_BOOT_TOP_BASE = 19'h7C000;
  localparam logic [18:0] BFCI_BOOT_TOP_END  = 19'h7FFFF;
  localparam logic [18:0] BFCI_BOOT_BOT_BASE = 19'h00000;

  localparam logic [18:0] BFCI_UNLOCK_ADDR1  = 19'h05555;
  localparam logic [18:0] BFCI_UNLOCK_ADDR2  = 19'h02AAA;
  localparam logic [7:0]  BFCI_UNLOCK_DATA1  = 8'hAA;
  localparam logic [7:0]  BFCI_UNLOCK_DATA2  = 8'h55;
  localparam logic [7:0]  BFCI_CMD_PROGRAM   = 8'hA0;
  localparam logic [7:0]  BFCI_CMD_ERASE_SET = 8'h80;
  localparam logic [7:0]  BFCI_CMD_SECTOR    = 8'h30;
  localparam logic [7:0]  BFCI_CMD_CHIP      = 8'h10;
  localparam logic [7:0]  BFCI_CMD_READ      = 8'hF0;
  localparam logic [7:0]  BFCI_CMD_ABORT     = 8'hFF;
  localparam logic [7:0]  BFCI_ERASED_BYTE   = 8'hFF;

  localparam int          BFCI_POLL_BIT      = 7;
  localparam int          BFCI_TOGGLE_BIT    = 6;

  // bus strobe timing, ns
  localparam int BFCI_CLK_NS        = 40;
  localparam int BFCI_T_WP_NS       = 50;
  localparam int BFCI_T_WPH_NS      = 35;
  localparam int BFCI_T_RC_NS       = 120;
  localparam int BFCI_T_DF_NS       = 50;
  localparam int BFCI_WP_CYC  = (BFCI_T_WP_NS + BFCI_CLK_NS - 1) / BFCI_CLK_NS;
  localparam int BFCI_WPH_CYC = (BFCI_T_WPH_NS + BFCI_CLK_NS - 1) / BFCI_CLK_NS;
  localparam int BFCI_RC_CYC  = (BFCI_T_RC_NS + BFCI_CLK_NS - 1) / BFCI_CLK_NS;
  localparam int BFCI_DF_CYC  = (BFCI_T_DF_NS + BFCI_CLK_NS - 1) / BFCI_CLK_NS;
  // busy time bounds, us
  localparam int BFCI_T_PROG_US     = 60;
  localparam int BFCI_T_SECT_US     = 10000;
  localparam int BFCI_T_CHIP_US     = 3000000;
  localparam int BFCI_CYC_PER_US    = 1000 / BFCI_CLK_NS;
  localparam int BFCI_PROG_CYC      = BFCI_T_PROG_US * BFCI_CYC_PER_US;
  localparam int BFCI_SECT_CYC      = BFCI_T_SECT_US * BFCI_CYC_PER_US;
  localparam int BFCI_CHIP_CYC      = BFCI_T_CHIP_US * BFCI_CYC_PER_US;

  localparam logic [2:0] BFCI_OP_READ    = 3'h0;
  localparam logic [2:0] BFCI_OP_PROGRAM = 3'h1;
  localparam logic [2:0] BFCI_OP_SECTOR  = 3'h2;
  localparam logic [2:0] BFCI_OP_CHIP    = 3'h3;
  localparam logic [2:0] BFCI_OP_RESET   = 3'h4;
  localparam logic [2:0] BFCI_OP_ABORT   = 3'h5;
  localparam logic [2:0] BFCI_OP_LOCK    = 3'h6;
  localparam logic [2:0] BFCI_OP_UNLOCK  = 3'h7;

  localparam int BFCI_MAX_CYCLES = 6;

endpackage

// File: core/bfci_bus_cycle.sv
`timescale 1ns/1ns
// one strobed bus cycle on the flash pins: write (we controlled) or read
module bfci_bus_cycle
  import bfci_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   start,
  input  wire logic                   is_write,
  input  wire logic                   hv_oe,
  input  wire logic                   hv_ce,
  input  wire logic [BFCI_ADDR_W-1:0] addr,
  input  wire logic [BFCI_DATA_W-1:0] wdata,
  input  wire logic [BFCI_DATA_W-1:0] dq_in,
  output logic                        done,
  output logic [BFCI_DATA_W-1:0]      rdata,
  output logic                        chip_select_low,
  output logic                        output_drive_low,
  output logic                        write_strobe_low,
  output logic                        hv_ce_level,
  output logic                        hv_oe_level,
  output logic [BFCI_ADDR_W-1:0]      address,
  output logic [BFCI_DATA_W-1:0]      dq_out,
  output logic                        dq_oe
);

  typedef enum logic [1:0] {BFCI_BC_IDLE, BFCI_BC_STROBE, BFCI_BC_RECOVER} bfci_bc_e;

  bfci_bc_e  st_q;
  logic [7:0] cnt_q;
  logic       wr_q;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q  <= BFCI_BC_IDLE;
      cnt_q <= 8'h00;
      wr_q  <= 1'b0;
    end else begin
      case (st_q)
        BFCI_BC_IDLE: begin
          if (start) begin
            st_q  <= BFCI_BC_STROBE;
            wr_q  <= is_write;
            cnt_q <= is_write ? 8'(BFCI_WP_CYC) : 8'(BFCI_RC_CYC);
          end
        end
        BFCI_BC_STROBE: begin
          if (cnt_q == 8'h01) begin
            st_q  <= BFCI_BC_RECOVER;
            cnt_q <= wr_q ? 8'(BFCI_WPH_CYC) : 8'(BFCI_DF_CYC);
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        BFCI_BC_RECOVER: begin
          if (cnt_q == 8'h01) begin
            st_q <= BFCI_BC_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: st_q <= BFCI_BC_IDLE;
      endcase
    end
  end

  // address and data held stable across the strobe so either latch edge sees them
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      address <= '0;
      dq_out  <= '0;
    end else if (start && st_q == BFCI_BC_IDLE) begin
      address <= addr;
      dq_out  <= wdata;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (st_q == BFCI_BC_STROBE && !wr_q && cnt_q == 8'h01) begin
      rdata <= dq_in;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      chip_select_low  <= 1'b1;
      output_drive_low <= 1'b1;
      write_strobe_low <= 1'b1;
      dq_oe            <= 1'b0;
      hv_ce_level      <= 1'b0;
      hv_oe_level      <= 1'b0;
    end else if (start && st_q == BFCI_BC_IDLE) begin
      // write strobe stays high for reads
      // address set on the same clock edge as the falling strobes
      chip_select_low  <= hv_ce ? 1'b1 : 1'b0;
      output_drive_low <= (is_write || hv_oe) ? 1'b1 : 1'b0;
      write_strobe_low <= is_write ? 1'b0 : 1'b1;
      dq_oe            <= is_write;
      hv_ce_level      <= hv_ce;
      hv_oe_level      <= hv_oe;
    end else if (st_q == BFCI_BC_STROBE && cnt_q == 8'h01) begin
      // both strobes rise together, data still driven
      // chip select and output drive rise to end the read
      chip_select_low  <= 1'b1;
      output_drive_low <= 1'b1;
      write_strobe_low <= 1'b1;
      hv_ce_level      <= 1'b0;
      hv_oe_level      <= 1'b0;
    end else if (st_q == BFCI_BC_RECOVER) begin
      dq_oe <= 1'b0;
    end
  end

  assign done = (st_q == BFCI_BC_RECOVER) && (cnt_q == 8'h01);

endmodule

// File: core/bfci_host.sv
`timescale 1ns/1ns
module bfci_host
  import bfci_pkg::*;
#(
  parameter int PROG_TIMEOUT_CYC = BFCI_PROG_CYC,
  parameter int SECT_TIMEOUT_CYC = BFCI_SECT_CYC,
  parameter int CHIP_TIMEOUT_CYC = BFCI_CHIP_CYC
) (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   cmd_valid,
  input  wire logic [2:0]             cmd_op,
  input  wire logic [BFCI_ADDR_W-1:0] cmd_addr,
  input  wire logic [BFCI_DATA_W-1:0] cmd_data,
  output logic                        cmd_ready,
  output logic                        rsp_valid,
  output logic [BFCI_DATA_W-1:0]      rsp_data,
  output logic                        rsp_timeout,
  output logic                        chip_select_low,
  output logic                        output_drive_low,
  output logic                        write_strobe_low,
  output logic                        hv_ce_level,
  output logic                        hv_oe_level,
  output logic                        id_voltage_address_line,
  output logic [BFCI_ADDR_W-1:0]      address,
  input  wire logic [BFCI_DATA_W-1:0] dq_in,
  output logic [BFCI_DATA_W-1:0]      dq_out,
  output logic                        dq_oe
);

  typedef enum logic [2:0] {
    BFCI_IDLE, BFCI_ISSUE, BFCI_WAIT, BFCI_POLL, BFCI_POLL_WAIT, BFCI_DONE
  } bfci_state_e;

  bfci_state_e             st_q;
  logic [2:0]              op_q;
  logic [BFCI_ADDR_W-1:0]  addr_q;
  logic [BFCI_DATA_W-1:0]  data_q;
  logic [2:0]              step_q;
  logic [2:0]              nsteps;
  logic [31:0]             tmo_q;
  logic                    have_prev_q;
  logic                    prev_tog_q;
  logic                    timeout_q;
  logic                    bc_start;
  logic                    bc_write;
  logic                    bc_done;
  logic [BFCI_ADDR_W-1:0]  bc_addr;
  logic [BFCI_DATA_W-1:0]  bc_wdata;
  logic [BFCI_DATA_W-1:0]  bc_rdata;
  logic                    is_hv;
  logic                    busy_op;
  logic                    settled;

  ////////////////////////////////////////////////////////////////////
  // sequence table per operation and step
  always_comb begin
    bc_addr  = BFCI_UNLOCK_ADDR1;
    bc_wdata = BFCI_UNLOCK_DATA1;
    nsteps   = 3'h1;
    case (op_q)
      // caller erases first; program only clears bits
      BFCI_OP_PROGRAM: begin
        nsteps = 3'h4;
        case (step_q)
          3'h1: begin bc_addr = BFCI_UNLOCK_ADDR2; bc_wdata = BFCI_UNLOCK_DATA2; end
          3'h2: bc_wdata = BFCI_CMD_PROGRAM;
          3'h3: begin bc_addr = addr_q; bc_wdata = data_q; end
          default: ;
        endcase
      end
      BFCI_OP_SECTOR, BFCI_OP_CHIP: begin
        nsteps = 3'h6;
        case (step_q)
          3'h1, 3'h4: begin bc_addr = BFCI_UNLOCK_ADDR2; bc_wdata = BFCI_UNLOCK_DATA2; end
          3'h2: bc_wdata = BFCI_CMD_ERASE_SET;
          3'h5: begin
            bc_addr  = (op_q == BFCI_OP_SECTOR) ? addr_q : BFCI_UNLOCK_ADDR1;
            bc_wdata = (op_q == BFCI_OP_SECTOR) ? BFCI_CMD_SECTOR : BFCI_CMD_CHIP;
          end
          default: ;
        endcase
      end
      BFCI_OP_RESET: begin bc_addr = addr_q; bc_wdata = BFCI_CMD_READ; end
      BFCI_OP_ABORT: begin bc_addr = BFCI_UNLOCK_ADDR1; bc_wdata = BFCI_CMD_ABORT; end
      BFCI_OP_READ, BFCI_OP_LOCK, BFCI_OP_UNLOCK: begin bc_addr = addr_q; bc_wdata = data_q; end
      default: ;
    endcase
  end

  assign is_hv    = (op_q == BFCI_OP_LOCK) || (op_q == BFCI_OP_UNLOCK);
  assign busy_op  = (op_q == BFCI_OP_PROGRAM) || (op_q == BFCI_OP_SECTOR) ||
                    (op_q == BFCI_OP_CHIP);
  assign bc_write = (op_q != BFCI_OP_READ);
  assign bc_start = (st_q == BFCI_ISSUE) || (st_q == BFCI_POLL);
  assign cmd_ready = (st_q == BFCI_IDLE);
  // toggle bit stable across two reads means finished
  // poll bit equals the loaded bit when finished
  assign settled = have_prev_q && (bc_rdata[BFCI_TOGGLE_BIT] == prev_tog_q) &&
                   ((op_q != BFCI_OP_PROGRAM) ||
                    (bc_rdata[BFCI_POLL_BIT] == data_q[BFCI_POLL_BIT]));

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q   <= BFCI_IDLE;
      op_q   <= BFCI_OP_READ;
      addr_q <= '0;
      data_q <= '0;
      step_q <= 3'h0;
    end else begin
      case (st_q)
        BFCI_IDLE: begin
          if (cmd_valid) begin
            op_q   <= cmd_op;
            addr_q <= cmd_addr;
            data_q <= cmd_data;
            step_q <= 3'h0;
            st_q   <= BFCI_ISSUE;
          end
        end
        BFCI_ISSUE: st_q <= BFCI_WAIT;
        BFCI_WAIT: begin
          if (bc_done) begin
            if (step_q + 3'h1 < nsteps) begin
              step_q <= step_q + 3'h1;
              st_q   <= BFCI_ISSUE;
            end else begin
              // no new writes until busy ends or the busy wait times out
              st_q <= busy_op ? BFCI_POLL : BFCI_DONE;
            end
          end
        end
        BFCI_POLL: st_q <= BFCI_POLL_WAIT;
        BFCI_POLL_WAIT: begin
          if (bc_done) begin
            st_q <= (settled || tmo_q == 32'h0000_0000) ? BFCI_DONE : BFCI_POLL;
          end
        end
        BFCI_DONE: st_q <= BFCI_IDLE;
        default: st_q <= BFCI_IDLE;
      endcase
    end
  end

  // status poll history; status reads use the target address
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      have_prev_q <= 1'b0;
      prev_tog_q  <= 1'b0;
    end else if (st_q == BFCI_ISSUE) begin
      have_prev_q <= 1'b0;
    end else if (st_q == BFCI_POLL_WAIT && bc_done) begin
      have_prev_q <= 1'b1;
      prev_tog_q  <= bc_rdata[BFCI_TOGGLE_BIT];
    end
  end

  // bounded busy wait, flagged if exceeded
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tmo_q     <= 32'h0000_0000;
      timeout_q <= 1'b0;
    end else if (st_q == BFCI_IDLE) begin
      timeout_q <= 1'b0;
    end else if (st_q == BFCI_WAIT && bc_done) begin
      tmo_q <= (op_q == BFCI_OP_PROGRAM) ? 32'(PROG_TIMEOUT_CYC) :
               (op_q == BFCI_OP_SECTOR)  ? 32'(SECT_TIMEOUT_CYC) : 32'(CHIP_TIMEOUT_CYC);
    end else if (st_q == BFCI_POLL_WAIT || st_q == BFCI_POLL) begin
      if (tmo_q != 32'h0000_0000) begin
        tmo_q <= tmo_q - 32'h0000_0001;
      end else if (st_q == BFCI_POLL_WAIT && bc_done && !settled) begin
        timeout_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid   <= 1'b0;
      rsp_data    <= '0;
      rsp_timeout <= 1'b0;
    end else begin
      rsp_valid <= (st_q == BFCI_DONE);
      if (st_q == BFCI_DONE) begin
        rsp_data    <= bc_rdata;
        rsp_timeout <= timeout_q;
      end
    end
  end

  // lock: high voltage on output drive and A9
  // unlock: high voltage also on chip select
  // identification voltage held only for these cycles
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      id_voltage_address_line <= 1'b0;
    end else begin
      id_voltage_address_line <= is_hv && (st_q == BFCI_ISSUE || st_q == BFCI_WAIT);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // chip select idles high, so the device rests in standby
  bfci_bus_cycle u_cycle (
    .clock            (clock),
    .sys_rst          (sys_rst),
    .start            (bc_start),
    .is_write         (bc_write && st_q == BFCI_ISSUE),
    .hv_oe            (is_hv),
    .hv_ce            (op_q == BFCI_OP_UNLOCK),
    .addr             (st_q == BFCI_POLL ? addr_q : bc_addr),
    .wdata            (bc_wdata),
    .dq_in            (dq_in),
    .done             (bc_done),
    .rdata            (bc_rdata),
    .chip_select_low  (chip_select_low),
    .output_drive_low (output_drive_low),
    .write_strobe_low (write_strobe_low),
    .hv_ce_level      (hv_ce_level),
    .hv_oe_level      (hv_oe_level),
    .address          (address),
    .dq_out           (dq_out),
    .dq_oe            (dq_oe)
  );

endmodule

// File: verification/bfci_host_properties.sv
`timescale 1ns/1ns
module bfci_host_properties (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        rsp_valid,
  input wire logic        chip_select_low,
  input wire logic        output_drive_low,
  input wire logic        write_strobe_low,
  input wire logic        hv_ce_level,
  input wire logic        hv_oe_level,
  input wire logic        id_voltage_address_line,
  input wire logic [18:0] address,
  input wire logic [7:0]  dq_out,
  input wire logic        dq_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  sequence s_wr;
    !write_strobe_low [*2] ##1 write_strobe_low;
  endsequence
  // output drive and chip select low together for three cycles, then output drive high for two float cycles before the next access
  sequence s_rd;
    (!output_drive_low && !chip_select_low) [*3] ##1 output_drive_low [*2];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_rd_no_write: assert property (!output_drive_low |-> write_strobe_low && !dq_oe)
    else $error("write or drive during read");
  a_rd_pulse: assert property ($fell(output_drive_low) |-> s_rd)
    else $error("read strobe shape");
  a_wr_pulse: assert property ($fell(write_strobe_low) |-> s_wr)
    else $error("write strobe width");
  a_wr_stable: assert property (!write_strobe_low && !$fell(write_strobe_low)
    |-> $stable(address) && $stable(dq_out))
    else $error("address or data moved in write");
  a_cs_with_we: assert property ($fell(write_strobe_low) && !hv_ce_level
    |-> !chip_select_low)
    else $error("write without chip select");
  a_dq_hold: assert property ($rose(write_strobe_low) |-> dq_oe)
    else $error("data released at strobe rise");
  a_idle_done: assert property (rsp_valid
    |-> chip_select_low && output_drive_low && write_strobe_low)
    else $error("pins not idle at completion");
  a_hv_lock: assert property (hv_oe_level |-> id_voltage_address_line && output_drive_low)
    else $error("lock pins inconsistent");
  a_hv_unlock: assert property (hv_ce_level |-> chip_select_low && hv_oe_level)
    else $error("unlock pins inconsistent");
  a_id_released: assert property (rsp_valid
    |-> !id_voltage_address_line && !hv_oe_level && !hv_ce_level)
    else $error("high voltage left on at completion");
  a_rsp_once: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
endmodule
bind bfci_host bfci_host_properties u_props (
  .clock(clock), .sys_rst(sys_rst), .rsp_valid(rsp_valid),
  .chip_select_low(chip_select_low), .output_drive_low(output_drive_low),
  .write_strobe_low(write_strobe_low), .hv_ce_level(hv_ce_level),
  .hv_oe_level(hv_oe_level), .id_voltage_address_line(id_voltage_address_line),
  .address(address), .dq_out(dq_out), .dq_oe(dq_oe)
);

// File: verification/bfci_flash_model.sv
`timescale 1ns/1ns
module bfci_flash_model
  import bfci_pkg::*;
#(
  parameter int PROG_NS = 600,
  parameter int SECT_NS = 1000,
  parameter int CHIP_NS = 3000
) (
  input  wire logic        chip_select_low,
  input  wire logic        output_drive_low,
  input  wire logic        write_strobe_low,
  input  wire logic        hv_ce_level,
  input  wire logic        hv_oe_level,
  input  wire logic        id_voltage_address_line,
  input  wire logic [18:0] address,
  input  wire logic [7:0]  dq_host,
  input  wire logic        slow,
  output logic      [7:0]  dq_dev
);
  logic [7:0]  mem [int];
  logic [18:0] lat_a;
  logic [7:0]  last_d;
  logic [7:0]  hold = 8'h00;
  logic        tog = 1'b0;
  logic        locked = 1'b0;
  logic        busy = 1'b0;
  int          step = 0;
  int          dur;
  wire         wr_on = !chip_select_low && !write_strobe_low;
  wire         rd_on = !chip_select_low && !output_drive_low && write_strobe_low;
  ////////////////////////////////////////////////////////////////////////
  // unwritten bytes read erased
  function automatic logic [7:0] rd(input logic [18:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : BFCI_ERASED_BYTE;
  endfunction
  // top boot block of sixteen sectors
  function automatic logic prot(input logic [18:0] a);
    return locked && a >= BFCI_BOOT_TOP_BASE;
  endfunction
  task automatic go(input int ns, input logic [7:0] d);
    last_d = d;
    tog = 1'b0;
    dur = slow ? 10 * ns : ns;
    busy = 1'b1;
  endtask
  always @(posedge busy) begin
    #(dur);
    busy = 1'b0;
  end
  task automatic wr_cmd(input logic [18:0] a, input logic [7:0] d);
    int s;
    s = step;
    step = 0;
    // busy ignores, bad data or read command resets
    if (busy || d == BFCI_CMD_READ)
      return;
    case (s)
      0, 3: if (a == BFCI_UNLOCK_ADDR1 && d == BFCI_UNLOCK_DATA1) step = s + 1;
      1, 4: if (a == BFCI_UNLOCK_ADDR2 && d == BFCI_UNLOCK_DATA2) step = s + 1;
      2: if (a == BFCI_UNLOCK_ADDR1 && d == BFCI_CMD_PROGRAM) step = 6;
         else if (a == BFCI_UNLOCK_ADDR1 && d == BFCI_CMD_ERASE_SET) step = 3;
      // sector of 1K bytes erased alone
      5: if (d == BFCI_CMD_SECTOR && !prot(a)) begin
        for (int i = 0; i < BFCI_SECTOR_BYTES; i++)
          mem.delete(int'(a) / BFCI_SECTOR_BYTES * BFCI_SECTOR_BYTES + i);
        go(SECT_NS, BFCI_ERASED_BYTE);
      end else if (d == BFCI_CMD_CHIP && a == BFCI_UNLOCK_ADDR1 && !locked) begin
        mem.delete();
        go(CHIP_NS, BFCI_ERASED_BYTE);
      end
      6: if (!prot(a)) begin
        mem[int'(a)] = rd(a) & d;
        go(PROG_NS, d);
      end
      default: ;
    endcase
  endtask
  always @(posedge wr_on) begin
    #1;
    lat_a = address;
  end
  always @(negedge wr_on)
    if (!hv_oe_level)
      wr_cmd(lat_a, dq_host);
  always @(negedge write_strobe_low) begin
    #1;
    if (hv_oe_level && id_voltage_address_line && hv_ce_level)
      locked = 1'b0;
    else if (hv_oe_level && id_voltage_address_line && !chip_select_low)
      locked = 1'b1;
  end
  // toggle on each read while busy
  always @(negedge rd_on) begin
    hold = dq_dev;
    if (busy)
      tog = ~tog;
  end
  // drive only while reading; released pins show no stale value
  always @* begin
    if (rd_on && busy)
      dq_dev = {~last_d[7], tog, last_d[5:0]};
    else if (rd_on)
      dq_dev = rd(address);
    else
      dq_dev = ~hold;
  end
endmodule

// File: verification/bfci_host_test.sv
`timescale 1ns/1ns
module bfci_host_test;
  import bfci_pkg::*;
  logic        clock, sys_rst, cmd_valid, cmd_ready, rsp_valid, rsp_timeout;
  logic        cs_low, oe_low, we_low, hv_ce, hv_oe, hv_a9, dq_oe, slow;
  logic [2:0]  cmd_op;
  logic [18:0] cmd_addr, addr;
  logic [7:0]  cmd_data, rsp_data, dq_out, dq_dev, prev;
  wire  [7:0]  dq_in = dq_oe ? dq_out : dq_dev;
  int          error_cnt, num_checks, n;

  bfci_host #(.PROG_TIMEOUT_CYC(50), .SECT_TIMEOUT_CYC(50), .CHIP_TIMEOUT_CYC(200)) DUT (
    .clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_timeout(rsp_timeout), .chip_select_low(cs_low),
    .output_drive_low(oe_low), .write_strobe_low(we_low), .hv_ce_level(hv_ce),
    .hv_oe_level(hv_oe), .id_voltage_address_line(hv_a9), .address(addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  bfci_flash_model u_flash (
    .chip_select_low(cs_low), .output_drive_low(oe_low), .write_strobe_low(we_low),
    .hv_ce_level(hv_ce), .hv_oe_level(hv_oe), .id_voltage_address_line(hv_a9),
    .address(addr), .dq_host(dq_in), .slow(slow), .dq_dev(dq_dev));
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until taken; completion wait is bounded
  task automatic run(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    if (cmd_ready !== 1'b1) begin
      error_cnt++;
      close_out();
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic run_ok(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d,
                        input logic to);
    run(op, a, d);
    check_bit(rsp_timeout, to);
  endtask
  task automatic rd_chk(input logic [18:0] a, input logic [7:0] exp);
    run(BFCI_OP_READ, a, 8'h00);
    check_byte(rsp_data, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_program();
    rd_chk(BFCI_BOOT_TOP_END, BFCI_ERASED_BYTE);
    run_ok(BFCI_OP_PROGRAM, 19'h003FF, 8'h11, 1'b0);
    check_byte(rsp_data, 8'h11);
    run_ok(BFCI_OP_PROGRAM, 19'h00400, 8'h22, 1'b0);
    run_ok(BFCI_OP_PROGRAM, 19'h00400, 8'h0F, 1'b0);
    rd_chk(19'h00400, 8'h02);
    run_ok(BFCI_OP_SECTOR, 19'h00123, 8'h00, 1'b0);
    check_byte(rsp_data, BFCI_ERASED_BYTE);
    rd_chk(19'h003FF, BFCI_ERASED_BYTE);
    rd_chk(19'h00400, 8'h02);
  endtask
  task automatic t_lock();
    run_ok(BFCI_OP_LOCK, BFCI_BOOT_TOP_BASE, 8'h00, 1'b0);
    run_ok(BFCI_OP_PROGRAM, BFCI_BOOT_TOP_BASE, 8'h00, 1'b1);
    run_ok(BFCI_OP_PROGRAM, 19'h7BFFF, 8'h33, 1'b0);
    rd_chk(BFCI_BOOT_TOP_BASE, BFCI_ERASED_BYTE);
    run_ok(BFCI_OP_UNLOCK, BFCI_BOOT_TOP_BASE, 8'h00, 1'b0);
    run_ok(BFCI_OP_PROGRAM, BFCI_BOOT_TOP_BASE, 8'h44, 1'b0);
    rd_chk(BFCI_BOOT_TOP_BASE, 8'h44);
  endtask
  task automatic t_reset_chip();
    run_ok(BFCI_OP_RESET, 19'h00000, 8'h00, 1'b0);
    run_ok(BFCI_OP_ABORT, BFCI_UNLOCK_ADDR1, 8'h00, 1'b0);
    rd_chk(19'h7BFFF, 8'h33);
    run_ok(BFCI_OP_CHIP, 19'h00000, 8'h00, 1'b0);
    rd_chk(BFCI_BOOT_TOP_BASE, BFCI_ERASED_BYTE);
    rd_chk(19'h00400, BFCI_ERASED_BYTE);
  endtask
  // slow erase outlives the host limit; the program after it must be ignored
  task automatic t_busy();
    int k;
    slow = 1'b1;
    run_ok(BFCI_OP_SECTOR, 19'h7BC00, 8'h00, 1'b1);
    run_ok(BFCI_OP_PROGRAM, 19'h7BC01, 8'h00, 1'b1);
    slow = 1'b0;
    // run() reuses n, so the settle loop keeps its own bound
    k = 0;
    do begin
      prev = rsp_data;
      run(BFCI_OP_READ, 19'h7BC01, 8'h00);
      k++;
    end while (rsp_data !== prev && k < 60);
    if (rsp_data !== prev) begin
      error_cnt++;
      close_out();
    end
    rd_chk(19'h7BC01, BFCI_ERASED_BYTE);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_addr = 19'h00000;
    cmd_data = 8'h00;
    slow = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    t_program();
    t_lock();
    t_reset_chip();
    t_busy();
    close_out();
  end
endmodule
